// file: hdl/tls_pkg.sv
// package: register map, reset values and limits for the torque limit selector
package tls_pkg;
   // register byte offsets
   localparam logic [7:0] TLS_OFS_FWD_INT   = 8'h00;
   localparam logic [7:0] TLS_OFS_REV_INT   = 8'h04;
   localparam logic [7:0] TLS_OFS_FWD_EXT   = 8'h08;
   localparam logic [7:0] TLS_OFS_REV_EXT   = 8'h0c;
   localparam logic [7:0] TLS_OFS_MOTOR_MAX = 8'h10;
   localparam logic [7:0] TLS_OFS_ASSIGN    = 8'h14;
   localparam logic [7:0] TLS_OFS_STATUS    = 8'h18;
   localparam logic [7:0] TLS_OFS_IRQ_STAT  = 8'h1c;
   localparam logic [7:0] TLS_OFS_IRQ_EN    = 8'h20;
   localparam logic [7:0] TLS_OFS_IRQ_CLR   = 8'h24;
   localparam logic [7:0] TLS_OFS_CMD_FWD   = 8'h28;
   localparam logic [7:0] TLS_OFS_CMD_REV   = 8'h2c;
   // reset values and the write ceiling, percent of rated torque
   localparam logic [15:0] TLS_RST_INT       = 16'h0320;
   localparam logic [15:0] TLS_RST_EXT       = 16'h0064;
   localparam logic [15:0] TLS_RST_MOTOR_MAX = 16'h0320;
   localparam logic [15:0] TLS_LIMIT_MAX     = 16'h0320;
   // terminal assignment field positions
   localparam int TLS_ASN_FWD_IN  = 0;
   localparam int TLS_ASN_REV_IN  = 1;
   localparam int TLS_ASN_CLT_OUT = 2;
   // status bit positions
   localparam int TLS_ST_FWD_CLAMP = 0;
   localparam int TLS_ST_REV_CLAMP = 1;
   localparam int TLS_ST_FWD_EXT   = 2;
   localparam int TLS_ST_REV_EXT   = 3;
   // interrupt events
   localparam int TLS_EV_CLAMP_ON  = 0;
   localparam int TLS_EV_CLAMP_OFF = 1;
   localparam int TLS_EV_NUM       = 2;
endpackage : tls_pkg

// file: hdl/tls_torque_limit_select.sv
// module: torque limit selector with apb registers, clamp logic and interrupt
`timescale 1ns/1ps
`default_nettype none

// How it works
// - internal limits always apply, reset 800
// - all limits are percent of rated
// - forward input on: min internal, external
// - forward input off: internal forward only
// - reverse input on: min internal, external
// - reverse input off: internal reverse only
// - external limits 0..800, reset 100
// - clamped output high while torque clamped
// - inputs act only when terminal assigned
// - clamped output driven only when assigned
// - limits above motor maximum use maximum
module tls_torque_limit_select
   import tls_pkg::*;
#(
   parameter int DW = 16
) (
   // clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // apb slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   // host limit pins
   input  wire logic          fwd_ext_limit_in,
   input  wire logic          rev_ext_limit_in,
   output logic               torque_clamped_out,
   // torque path, magnitudes in percent of rated
   input  wire logic [DW-1:0] cmd_fwd_torque,
   input  wire logic [DW-1:0] cmd_rev_torque,
   output logic      [DW-1:0] lim_fwd_torque,
   output logic      [DW-1:0] lim_rev_torque,
   // interrupt
   output logic               irq
);

   // parameter check: ten bits hold the 800 percent ceiling, the bus word caps at 32
   if (DW < 10 || DW > 32) begin : g_dw_check
      $error("tls_torque_limit_select: DW must be 10..32");
   end

   // register storage
   logic [15:0] forward_internal_torque_limit;
   logic [15:0] reverse_internal_torque_limit;
   logic [15:0] forward_external_torque_limit;
   logic [15:0] reverse_external_torque_limit;
   logic [15:0] motor_max_torque;
   logic [2:0]  terminal_assignment;
   logic [TLS_EV_NUM-1:0] irq_stat;
   logic [TLS_EV_NUM-1:0] irq_en;

   // pin synchronisers, bit 0 forward, bit 1 reverse
   wire  [1:0]  pin_raw = {rev_ext_limit_in, fwd_ext_limit_in};
   wire  [1:0]  pin_sync;
   wire         fwd_sync = pin_sync[0];
   wire         rev_sync = pin_sync[1];
   // last cycle's clamp state, for the start and end events
   logic        clamp_prev;

   // clamp a written value to the legal range
   function automatic logic [15:0] tls_sat(input logic [31:0] v);
      tls_sat = (v[31:16] != 16'h0000 || v[15:0] > TLS_LIMIT_MAX) ? TLS_LIMIT_MAX : v[15:0];
   endfunction : tls_sat

   // smaller of two limits
   function automatic logic [15:0] tls_min(input logic [15:0] a, input logic [15:0] b);
      tls_min = (a < b) ? a : b;
   endfunction : tls_min

   // register map, one 32-bit word each, values in bits 15:0:
   //   0x00 forward internal limit      0x04 reverse internal limit
   //   0x08 forward external limit      0x0c reverse external limit
   //   0x10 motor maximum torque        0x14 terminal assignment
   //   0x18 clamp status (ro)           0x1c event status (ro)
   //   0x20 event enable                0x24 event clear (wo, reads 0)
   //   0x28 effective forward (ro)      0x2c effective reverse (ro)
   // an unmapped address or a write to a read-only word answers with pslverr
   // apb decode
   wire        acc       = psel && penable;
   wire        wr        = acc && pwrite;
   wire        hit_fi    = paddr == TLS_OFS_FWD_INT;
   wire        hit_ri    = paddr == TLS_OFS_REV_INT;
   wire        hit_fe    = paddr == TLS_OFS_FWD_EXT;
   wire        hit_re    = paddr == TLS_OFS_REV_EXT;
   wire        hit_mm    = paddr == TLS_OFS_MOTOR_MAX;
   wire        hit_as    = paddr == TLS_OFS_ASSIGN;
   wire        hit_st    = paddr == TLS_OFS_STATUS;
   wire        hit_is    = paddr == TLS_OFS_IRQ_STAT;
   wire        hit_ie    = paddr == TLS_OFS_IRQ_EN;
   wire        hit_ic    = paddr == TLS_OFS_IRQ_CLR;
   wire        hit_cf    = paddr == TLS_OFS_CMD_FWD;
   wire        hit_cr    = paddr == TLS_OFS_CMD_REV;
   wire        mapped    = hit_fi | hit_ri | hit_fe | hit_re | hit_mm | hit_as
                         | hit_st | hit_is | hit_ie | hit_ic | hit_cf | hit_cr;
   wire        bad_wr    = pwrite && (hit_st || hit_is || hit_cf || hit_cr);

   // write strobes, one per writable word; the access cycle is the write edge
   wire        we_fi     = wr && hit_fi;
   wire        we_ri     = wr && hit_ri;
   wire        we_fe     = wr && hit_fe;
   wire        we_re     = wr && hit_re;
   wire        we_mm     = wr && hit_mm;
   wire        we_as     = wr && hit_as;
   wire        we_ie     = wr && hit_ie;
   wire        we_ic     = wr && hit_ic;
   // the answer cycle follows every setup cycle, so pready never waits
   wire        setup     = psel && !penable;
   wire        rd_setup  = setup && !pwrite;

   // effective external inputs, ignored until assigned to a terminal
   // terminal gating
   wire fwd_ext_on = fwd_sync && terminal_assignment[TLS_ASN_FWD_IN];
   wire rev_ext_on = rev_sync && terminal_assignment[TLS_ASN_REV_IN];

   // effective limits
   // motor maximum cap
   wire [15:0] fi_cap = tls_min(forward_internal_torque_limit, motor_max_torque);
   wire [15:0] ri_cap = tls_min(reverse_internal_torque_limit, motor_max_torque);
   wire [15:0] fe_cap = tls_min(forward_external_torque_limit, motor_max_torque);
   wire [15:0] re_cap = tls_min(reverse_external_torque_limit, motor_max_torque);
   wire [15:0] eff_fwd = fwd_ext_on ? tls_min(fi_cap, fe_cap) : fi_cap;
   wire [15:0] eff_rev = rev_ext_on ? tls_min(ri_cap, re_cap) : ri_cap;

   // per-direction comparison against the effective limit
   // compare and clamp
   wire [DW-1:0] eff_fwd_w = DW'(eff_fwd);
   wire [DW-1:0] eff_rev_w = DW'(eff_rev);
   wire          fwd_over  = cmd_fwd_torque > eff_fwd_w;
   wire          rev_over  = cmd_rev_torque > eff_rev_w;
   wire [DW-1:0] next_lim_fwd = fwd_over ? eff_fwd_w : cmd_fwd_torque;
   wire [DW-1:0] next_lim_rev = rev_over ? eff_rev_w : cmd_rev_torque;
   wire          clamp_now = fwd_over || rev_over;

   // interrupt events: clamping starts or ends
   wire [TLS_EV_NUM-1:0] ev;
   assign ev[TLS_EV_CLAMP_ON]  = clamp_now && !clamp_prev;
   assign ev[TLS_EV_CLAMP_OFF] = !clamp_now && clamp_prev;
   wire [TLS_EV_NUM-1:0] clr_mask = we_ic ? pwdata[TLS_EV_NUM-1:0] : '0;
   // set wins over a clear in the same cycle
   wire [TLS_EV_NUM-1:0] next_irq_stat = (irq_stat & ~clr_mask) | ev;

   // read words, each zero-extended to the bus width
   wire [31:0] rw_fi = {16'h0000, forward_internal_torque_limit};
   wire [31:0] rw_ri = {16'h0000, reverse_internal_torque_limit};
   wire [31:0] rw_fe = {16'h0000, forward_external_torque_limit};
   wire [31:0] rw_re = {16'h0000, reverse_external_torque_limit};
   wire [31:0] rw_mm = {16'h0000, motor_max_torque};
   wire [31:0] rw_as = {29'h0, terminal_assignment};
   wire [31:0] rw_st = {28'h0, rev_ext_on, fwd_ext_on, rev_over, fwd_over};
   wire [31:0] rw_is = {{(32 - TLS_EV_NUM){1'b0}}, irq_stat};
   wire [31:0] rw_ie = {{(32 - TLS_EV_NUM){1'b0}}, irq_en};
   wire [31:0] rw_cf = {16'h0000, eff_fwd};
   wire [31:0] rw_cr = {16'h0000, eff_rev};
   // read select: the address hits are one-hot, so and-or is a plain mux
   wire [31:0] rd = ({32{hit_fi}} & rw_fi)
                  | ({32{hit_ri}} & rw_ri)
                  | ({32{hit_fe}} & rw_fe)
                  | ({32{hit_re}} & rw_re)
                  | ({32{hit_mm}} & rw_mm)
                  | ({32{hit_as}} & rw_as)
                  | ({32{hit_st}} & rw_st)
                  | ({32{hit_is}} & rw_is)
                  | ({32{hit_ie}} & rw_ie)
                  | ({32{hit_cf}} & rw_cf)
                  | ({32{hit_cr}} & rw_cr);

   // two-flop synchronisers on the host pins; only the second flop is read
   for (genvar gi = 0; gi < 2; gi++) begin : g_pin_sync
      logic meta;
      logic sync;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            meta <= 1'b0;
            sync <= 1'b0;
         end else begin
            meta <= pin_raw[gi];
            sync <= meta;
         end
      end
      assign pin_sync[gi] = sync;
   end

   // forward internal limit, written value takes effect at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         forward_internal_torque_limit <= TLS_RST_INT;
      end else if (we_fi) begin
         forward_internal_torque_limit <= tls_sat(pwdata);
      end
   end

   // reverse internal limit, written value takes effect at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reverse_internal_torque_limit <= TLS_RST_INT;
      end else if (we_ri) begin
         reverse_internal_torque_limit <= tls_sat(pwdata);
      end
   end

   // forward external limit, used only while its pin is on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         forward_external_torque_limit <= TLS_RST_EXT;
      end else if (we_fe) begin
         forward_external_torque_limit <= tls_sat(pwdata);
      end
   end

   // reverse external limit, used only while its pin is on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reverse_external_torque_limit <= TLS_RST_EXT;
      end else if (we_re) begin
         reverse_external_torque_limit <= tls_sat(pwdata);
      end
   end

   // motor maximum torque, caps every limit setting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motor_max_torque <= TLS_RST_MOTOR_MAX;
      end else if (we_mm) begin
         motor_max_torque <= tls_sat(pwdata);
      end
   end

   // terminal assignment: pins and flag stay dead until assigned
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         terminal_assignment <= 3'h0;
      end else if (we_as) begin
         terminal_assignment <= pwdata[2:0];
      end
   end

   // sticky event status, a clear never hides a new event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= next_irq_stat;
      end
   end

   // event enable mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en <= '0;
      end else if (we_ie) begin
         irq_en <= pwdata[TLS_EV_NUM-1:0];
      end
   end

   // clamp history for the edge events; reset matches the idle state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clamp_prev <= 1'b0;
      end else begin
         clamp_prev <= clamp_now;
      end
   end

   // forward torque to the current loop, one cycle after the command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lim_fwd_torque <= '0;
      end else begin
         lim_fwd_torque <= next_lim_fwd;
      end
   end

   // reverse torque to the current loop, one cycle after the command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lim_rev_torque <= '0;
      end else begin
         lim_rev_torque <= next_lim_rev;
      end
   end

   // clamped flag, aligned with the limited torque it describes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         torque_clamped_out <= 1'b0;
      end else begin
         torque_clamped_out <= clamp_now && terminal_assignment[TLS_ASN_CLT_OUT];
      end
   end

   // level interrupt, follows the status it will hold after this edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_irq_stat & irq_en);
      end
   end

   // ready in the access cycle, one cycle per transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   // error answer for unmapped words and read-only writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup && (!mapped || bad_wr);
      end
   end

   // read data stands with pready only, zero otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= rd_setup ? rd : 32'h0000_0000;
      end
   end

endmodule : tls_torque_limit_select

`default_nettype wire

// file: bench/tls_checker_assertions.sv
// checker: port-level properties of the torque limit selector
`timescale 1ns/1ps
`default_nettype none
module tls_checker
   import tls_pkg::*;
#(
   parameter int DW = 16
) (
   // clock and reset
   input wire logic          pclk,
   input wire logic          presetn,
   // apb
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pready,
   input wire logic [31:0]   prdata,
   // torque path
   input wire logic          torque_clamped_out,
   input wire logic [DW-1:0] cmd_fwd_torque,
   input wire logic [DW-1:0] cmd_rev_torque,
   input wire logic [DW-1:0] lim_fwd_torque,
   input wire logic [DW-1:0] lim_rev_torque
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_fwd_below_cmd: assert property (lim_fwd_torque <= $past(cmd_fwd_torque))
      else $error("forward output above command");
   a_rev_below_cmd: assert property (lim_rev_torque <= $past(cmd_rev_torque))
      else $error("reverse output above command");
   a_zero_passes: assert property ($past(cmd_fwd_torque) == '0 |-> lim_fwd_torque == '0)
      else $error("zero command not passed");
   a_fwd_max_cap: assert property (lim_fwd_torque <= TLS_LIMIT_MAX)
      else $error("forward output above maximum");
   a_rev_max_cap: assert property (lim_rev_torque <= TLS_LIMIT_MAX)
      else $error("reverse output above maximum");
   a_clamp_has_cause: assert property (torque_clamped_out |->
      ($past(cmd_fwd_torque) > lim_fwd_torque || $past(cmd_rev_torque) > lim_rev_torque))
      else $error("clamp flag without clamping");
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   c_clamped: cover property ($rose(torque_clamped_out));
   c_read: cover property (pready && prdata != 32'h0);
   c_zero: cover property (lim_fwd_torque == '0 && lim_rev_torque == '0);
endmodule : tls_checker
bind tls_torque_limit_select tls_checker #(.DW(DW)) tls_checker_inst (.pclk, .presetn, .psel, .penable,
   .pready, .prdata, .torque_clamped_out, .cmd_fwd_torque, .cmd_rev_torque, .lim_fwd_torque, .lim_rev_torque);
`default_nettype wire

// file: bench/tls_host_model.sv
// model: host controller holding the external limit pins
`timescale 1ns/1ps
`default_nettype none
module tls_host_model (
   // clock
   input  wire logic pclk,
   // limit pins
   output logic      fwd_ext_limit_in,
   output logic      rev_ext_limit_in
);
   // pins start released
   initial begin
      fwd_ext_limit_in = 1'b0;
      rev_ext_limit_in = 1'b0;
   end
   // levels held steady until asked again
   task set_pins(input logic f, input logic r);
      @(posedge pclk);
      fwd_ext_limit_in <= f;
      rev_ext_limit_in <= r;
   endtask : set_pins
endmodule : tls_host_model
`default_nettype wire

// file: bench/tb_top.sv
// testbench: registers, limit selection, pins and interrupt
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tls_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [15:0] cmd_fwd_torque = '0, cmd_rev_torque = '0, lim_fwd_torque, lim_rev_torque;
   logic        pready, pslverr, torque_clamped_out, irq;
   wire logic   fwd_ext_limit_in, rev_ext_limit_in;
   int          mismatches = 0, n_compared = 0;
   always #2.5 pclk = ~pclk;
   tls_torque_limit_select tls_torque_limit_select_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .fwd_ext_limit_in, .rev_ext_limit_in, .torque_clamped_out,
      .cmd_fwd_torque, .cmd_rev_torque, .lim_fwd_torque, .lim_rev_torque, .irq);
   tls_host_model tls_host_model_inst (.pclk, .fwd_ext_limit_in, .rev_ext_limit_in);
   task end_of_test;
      if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer, waits for ready under a bound
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      int i;
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         mismatches++;
         end_of_test;
      end
      r = prdata; e = pslverr; psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask : apb
   task rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, x);
   endtask : rd
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   // apply commands and let pins and outputs settle
   task torque(input logic [15:0] f, input logic [15:0] r);
      cmd_fwd_torque <= f; cmd_rev_torque <= r;
      repeat (5) @(posedge pclk);
   endtask : torque
   task lims(input logic [15:0] f, input logic [15:0] r, input logic c);
      chk(lim_fwd_torque, f); chk(lim_rev_torque, r); chk(torque_clamped_out, c);
   endtask : lims
   task t_reset;
      rd(TLS_OFS_FWD_INT, 32'h320); rd(TLS_OFS_REV_INT, 32'h320);
      rd(TLS_OFS_FWD_EXT, 32'h64); rd(TLS_OFS_REV_EXT, 32'h64);
   endtask : t_reset
   task t_internal;
      torque(16'd900, 16'd5);
      lims(16'h320, 16'd5, 1'b0);
      wr(TLS_OFS_FWD_INT, 32'd900);
      rd(TLS_OFS_FWD_INT, 32'h320);
      wr(TLS_OFS_FWD_INT, 32'd300); wr(TLS_OFS_REV_INT, 32'd200);
   endtask : t_internal
   task t_external;
      tls_host_model_inst.set_pins(1'b1, 1'b1);
      torque(16'd900, 16'd900);
      lims(16'd300, 16'd200, 1'b0);
      wr(TLS_OFS_ASSIGN, 32'h7);
      torque(16'd900, 16'd900);
      lims(16'd100, 16'd100, 1'b1);
      tls_host_model_inst.set_pins(1'b0, 1'b0);
      torque(16'd900, 16'd900);
      lims(16'd300, 16'd200, 1'b1);
   endtask : t_external
   // a lower motor maximum caps the forward internal limit
   task t_motor_max;
      wr(TLS_OFS_MOTOR_MAX, 32'd50);
      torque(16'd900, 16'd40);
      lims(16'd50, 16'd40, 1'b1);
      rd(TLS_OFS_CMD_FWD, 32'd50);
      wr(TLS_OFS_MOTOR_MAX, 32'h320);
   endtask : t_motor_max
   task t_irq;
      logic [31:0] r;
      logic        e;
      wr(TLS_OFS_IRQ_EN, 32'h1); torque(16'd0, 16'd0);
      lims(16'd0, 16'd0, 0);
      wr(TLS_OFS_IRQ_CLR, 32'h3); @(posedge pclk);
      chk(irq, 0);
      torque(16'd900, 16'd0);
      chk(irq, 1);
      wr(TLS_OFS_IRQ_CLR, 32'h1); @(posedge pclk);
      chk(irq, 0);
      apb(1'b0, 8'h30, 32'h0000_0000, r, e);
      chk(e, 1);
      apb(1'b1, TLS_OFS_STATUS, 32'h1, r, e);
      chk(e, 1);
   endtask : t_irq
   // main sequence
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_reset;
      t_internal;
      t_external;
      t_motor_max;
      t_irq;
      end_of_test;
   end
endmodule : tb_top
`default_nettype wire
